//--- verilog/hall_cfg_map.svh
`ifndef HALL_CFG_MAP_SVH
`define HALL_CFG_MAP_SVH

// Register offsets on the host register port
`define ADDR_GENERAL_SETUP 8'h03
`define ADDR_THR_ONE 8'h04
`define ADDR_THR_TWO 8'h05
`define ADDR_THR_THREE 8'h06
`define REG_COUNT 4
`define REG_RESET 8'h00
`define READ_UNMAPPED 8'h00

// General setup field positions
`define SGS_TEMP_AVG 7
`define SGS_IRQ_POL 6
`define SGS_THR_DIR 5
`define SGS_GAIN_SEL 4
`define SGS_ANGLE_HI 3
`define SGS_ANGLE_LO 2
`define SGS_XY_RANGE 1
`define SGS_Z_RANGE 0

// Field encodings
`define TEMP_AVG_SINGLE 1'h0
`define POL_ACTIVE_LOW 1'h0
`define DIR_ABOVE 1'h0
`define GAIN_FIRST 1'h0
`define RANGE_NARROW 1'h0
`define AXIS_EN_NONE 4'h0
`define PAIR_NONE 2'h0
`define PAIR_XY 2'h1
`define PAIR_YZ 2'h2
`define PAIR_XZ 2'h3
`define THRESHOLD_FUNCTION_SELECT_OFF 2'h0
`define THRESHOLD_FUNCTION_SELECT_ANGLE 2'h1
`define THRESHOLD_FUNCTION_SELECT_FIELD 2'h2
`define THRESHOLD_FUNCTION_SELECT_MAG 2'h3
`define LEVEL_ZERO 8'h00

`endif

//--- verilog/hall_cfg_pkg.sv
`default_nettype none
package hall_cfg_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic signed [7:0] level_t;
    typedef enum logic [1:0] {
        AXIS_NONE,
        AXIS_X,
        AXIS_Y,
        AXIS_Z
    } axis_t;
endpackage : hall_cfg_pkg
`default_nettype wire

//--- verilog/threshold_route.sv
`default_nettype none
`include "hall_cfg_map.svh"
module threshold_route import hall_cfg_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_threshold_function_select,
    input wire logic [7:0] i_threshold_field_one,
    input wire logic [7:0] i_threshold_field_two,
    input wire logic [7:0] i_threshold_field_three,
    output logic signed [7:0] o_angle_reference_level,
    output logic signed [7:0] o_angle_band_width,
    output logic signed [7:0] o_angle_offset_level,
    output logic signed [7:0] o_x_low_level,
    output logic signed [7:0] o_y_low_level,
    output logic signed [7:0] o_z_low_level,
    output logic signed [7:0] o_magnitude_low_level,
    output logic signed [7:0] o_magnitude_high_level
);
    level_t ang_ref_next, ang_band_next, ang_off_next;
    level_t x_lo_next, y_lo_next, z_lo_next, mag_lo_next, mag_hi_next;

    // Unselected roles read as zero, except the angle offset, which the magnitude select also loads from field three
    always_comb begin
        ang_ref_next = level_t'(`LEVEL_ZERO);
        ang_band_next = level_t'(`LEVEL_ZERO);
        ang_off_next = level_t'(`LEVEL_ZERO);
        x_lo_next = level_t'(`LEVEL_ZERO);
        y_lo_next = level_t'(`LEVEL_ZERO);
        z_lo_next = level_t'(`LEVEL_ZERO);
        mag_lo_next = level_t'(`LEVEL_ZERO);
        mag_hi_next = level_t'(`LEVEL_ZERO);
        case (i_threshold_function_select)
            `THRESHOLD_FUNCTION_SELECT_ANGLE: begin
                ang_ref_next = level_t'(i_threshold_field_one);
                ang_band_next = level_t'(i_threshold_field_two);
                ang_off_next = level_t'(i_threshold_field_three);
            end
            `THRESHOLD_FUNCTION_SELECT_FIELD: begin
                x_lo_next = level_t'(i_threshold_field_one);
                y_lo_next = level_t'(i_threshold_field_two);
                z_lo_next = level_t'(i_threshold_field_three);
            end
            `THRESHOLD_FUNCTION_SELECT_MAG: begin
                mag_lo_next = level_t'(i_threshold_field_one);
                mag_hi_next = level_t'(i_threshold_field_two);
                ang_off_next = level_t'(i_threshold_field_three);
            end
            default: begin
                ang_ref_next = level_t'(`LEVEL_ZERO);
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_angle_reference_level <= level_t'(`LEVEL_ZERO);
            o_angle_band_width <= level_t'(`LEVEL_ZERO);
            o_angle_offset_level <= level_t'(`LEVEL_ZERO);
            o_x_low_level <= level_t'(`LEVEL_ZERO);
            o_y_low_level <= level_t'(`LEVEL_ZERO);
            o_z_low_level <= level_t'(`LEVEL_ZERO);
            o_magnitude_low_level <= level_t'(`LEVEL_ZERO);
            o_magnitude_high_level <= level_t'(`LEVEL_ZERO);
        end else begin
            o_angle_reference_level <= ang_ref_next;
            o_angle_band_width <= ang_band_next;
            o_angle_offset_level <= ang_off_next;
            o_x_low_level <= x_lo_next;
            o_y_low_level <= y_lo_next;
            o_z_low_level <= z_lo_next;
            o_magnitude_low_level <= mag_lo_next;
            o_magnitude_high_level <= mag_hi_next;
        end
    end
endmodule : threshold_route
`default_nettype wire

//--- verilog/hall_sensor_config_threshold_regs.sv
`default_nettype none
`include "hall_cfg_map.svh"
module hall_sensor_config_threshold_regs import hall_cfg_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port from the serial-bus engine
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // Settings held elsewhere in the device
    input wire logic [3:0] i_axis_channel_enable,
    input wire logic [1:0] i_threshold_function_select,
    // Raw events from the compare logic
    input wire logic i_irq_event,
    input wire logic i_field_above_threshold,
    input wire logic i_field_below_threshold,
    // Decoded controls
    output logic o_temp_single_conversion,
    output logic o_temp_filtered,
    output logic o_interrupt_pin_n,
    output logic o_threshold_condition,
    output logic o_angle_enable,
    output axis_t o_angle_first_axis,
    output axis_t o_angle_second_axis,
    output axis_t o_gain_axis,
    output logic o_xy_wide_range,
    output logic o_z_wide_range,
    output logic signed [7:0] o_angle_reference_level,
    output logic signed [7:0] o_angle_band_width,
    output logic signed [7:0] o_angle_offset_level,
    output logic signed [7:0] o_x_low_level,
    output logic signed [7:0] o_y_low_level,
    output logic signed [7:0] o_z_low_level,
    output logic signed [7:0] o_magnitude_low_level,
    output logic signed [7:0] o_magnitude_high_level
);
    localparam reg_byte_t REG_ADDR [`REG_COUNT] = '{
        `ADDR_GENERAL_SETUP, `ADDR_THR_ONE, `ADDR_THR_TWO, `ADDR_THR_THREE
    };

    reg_byte_t bank_reg [`REG_COUNT];
    reg_byte_t bank_next [`REG_COUNT];
    logic [`REG_COUNT-1:0] hit;

    // Register storage, one entry per mapped offset
    genvar gi;
    generate
        for (gi = 0; gi < `REG_COUNT; gi++) begin : g_bank
            assign hit[gi] = (i_addr == REG_ADDR[gi]);
            always_comb begin
                bank_next[gi] = bank_reg[gi];
                if (i_wr_en && hit[gi]) begin
                    bank_next[gi] = i_wr_data;
                end
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    bank_reg[gi] <= `REG_RESET;
                end else begin
                    bank_reg[gi] <= bank_next[gi];
                end
            end
        end
    endgenerate

    // Read path: one cycle latency, unmapped offsets return zero
    reg_byte_t rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;

    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = i_rd_en;
        if (i_rd_en) begin
            rd_data_next = `READ_UNMAPPED;
            for (int k = 0; k < `REG_COUNT; k++) begin
                if (hit[k]) begin
                    rd_data_next = bank_reg[k];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_data_reg <= `REG_RESET;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_rd_valid = rd_valid_reg;

    // Decoded controls from the general setup register
    reg_byte_t setup;
    logic [1:0] pair;
    assign setup = bank_reg[0];
    assign pair = setup[`SGS_ANGLE_HI:`SGS_ANGLE_LO];

    logic temp_single_reg, temp_single_next;
    logic temp_filt_reg, temp_filt_next;
    logic pin_reg, pin_next;
    logic thr_cond_reg, thr_cond_next;
    logic angle_en_reg, angle_en_next;
    axis_t first_reg, first_next;
    axis_t second_reg, second_next;
    axis_t gain_reg, gain_next;
    logic xy_wide_reg, xy_wide_next;
    logic z_wide_reg, z_wide_next;

    always_comb begin
        temp_single_next = (setup[`SGS_TEMP_AVG] == `TEMP_AVG_SINGLE)
            && (i_axis_channel_enable != `AXIS_EN_NONE);
        temp_filt_next = (setup[`SGS_TEMP_AVG] != `TEMP_AVG_SINGLE);

        if (setup[`SGS_IRQ_POL] == `POL_ACTIVE_LOW) begin
            pin_next = ~i_irq_event;
        end else begin
            pin_next = i_irq_event;
        end

        // No compare can fire while thresholds are switched off
        if (i_threshold_function_select == `THRESHOLD_FUNCTION_SELECT_OFF) begin
            thr_cond_next = 1'b0;
        end else if (setup[`SGS_THR_DIR] == `DIR_ABOVE) begin
            thr_cond_next = i_field_above_threshold;
        end else begin
            thr_cond_next = i_field_below_threshold;
        end

        case (pair)
            `PAIR_XY: begin
                first_next = AXIS_X;
                second_next = AXIS_Y;
            end
            `PAIR_YZ: begin
                first_next = AXIS_Y;
                second_next = AXIS_Z;
            end
            `PAIR_XZ: begin
                first_next = AXIS_X;
                second_next = AXIS_Z;
            end
            default: begin
                first_next = AXIS_NONE;
                second_next = AXIS_NONE;
            end
        endcase
        angle_en_next = (pair != `PAIR_NONE);

        gain_next = (setup[`SGS_GAIN_SEL] == `GAIN_FIRST) ? first_next : second_next;

        xy_wide_next = (setup[`SGS_XY_RANGE] != `RANGE_NARROW);
        z_wide_next = (setup[`SGS_Z_RANGE] != `RANGE_NARROW);
    end

    // Reset values match an all-zero setup byte with no event pending and no axis channel enabled
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            temp_single_reg <= 1'b0;
            temp_filt_reg <= 1'b0;
            pin_reg <= 1'b1;
            thr_cond_reg <= 1'b0;
            angle_en_reg <= 1'b0;
            first_reg <= AXIS_NONE;
            second_reg <= AXIS_NONE;
            gain_reg <= AXIS_NONE;
            xy_wide_reg <= 1'b0;
            z_wide_reg <= 1'b0;
        end else begin
            temp_single_reg <= temp_single_next;
            temp_filt_reg <= temp_filt_next;
            pin_reg <= pin_next;
            thr_cond_reg <= thr_cond_next;
            angle_en_reg <= angle_en_next;
            first_reg <= first_next;
            second_reg <= second_next;
            gain_reg <= gain_next;
            xy_wide_reg <= xy_wide_next;
            z_wide_reg <= z_wide_next;
        end
    end

    assign o_temp_single_conversion = temp_single_reg;
    assign o_temp_filtered = temp_filt_reg;
    assign o_interrupt_pin_n = pin_reg;
    assign o_threshold_condition = thr_cond_reg;
    assign o_angle_enable = angle_en_reg;
    assign o_angle_first_axis = first_reg;
    assign o_angle_second_axis = second_reg;
    assign o_gain_axis = gain_reg;
    assign o_xy_wide_range = xy_wide_reg;
    assign o_z_wide_range = z_wide_reg;

    // Field bytes are reinterpreted as signed levels by role
    threshold_route u_threshold_route (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_threshold_function_select(i_threshold_function_select),
        .i_threshold_field_one(bank_reg[1]),
        .i_threshold_field_two(bank_reg[2]),
        .i_threshold_field_three(bank_reg[3]),
        .o_angle_reference_level(o_angle_reference_level),
        .o_angle_band_width(o_angle_band_width),
        .o_angle_offset_level(o_angle_offset_level),
        .o_x_low_level(o_x_low_level),
        .o_y_low_level(o_y_low_level),
        .o_z_low_level(o_z_low_level),
        .o_magnitude_low_level(o_magnitude_low_level),
        .o_magnitude_high_level(o_magnitude_high_level)
    );
endmodule : hall_sensor_config_threshold_regs
`default_nettype wire

//--- dv/hall_cfg_properties.sv
`default_nettype none
module hall_cfg_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic o_rd_valid,
    input wire logic [3:0] i_axis_channel_enable,
    input wire logic [1:0] i_threshold_function_select,
    input wire logic i_irq_event,
    input wire logic i_field_above_threshold,
    input wire logic i_field_below_threshold,
    input wire logic o_temp_single_conversion,
    input wire logic o_temp_filtered,
    input wire logic o_interrupt_pin_n,
    input wire logic o_threshold_condition,
    input wire logic o_angle_enable,
    input wire logic o_xy_wide_range,
    input wire logic o_z_wide_range
);
    // Shadow of the setup byte, so decodes can be tied to what the host wrote
    logic [7:0] s_reg;
    logic [7:0] s_next;
    always_comb begin
        s_next = s_reg;
        if (!i_rst_n)
            s_next = 8'h00;
        else if (i_wr_en && i_addr == 8'h03)
            s_next = i_wr_data;
    end
    always_ff @(posedge i_clk) begin
        s_reg <= s_next;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_answer;
        i_rd_en |=> o_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_pulse;
        !i_rd_en |=> !o_rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("stray read valid");
    property p_pin;
        $past(i_rst_n) |-> o_interrupt_pin_n == ($past(s_reg[6]) ~^ $past(i_irq_event));
    endproperty
    a_pin: assert property (p_pin) else $error("pin polarity wrong");
    property p_cond;
        $past(i_rst_n) |-> o_threshold_condition == ($past(i_threshold_function_select) != 2'h0
            && ($past(s_reg[5]) ? $past(i_field_below_threshold)
            : $past(i_field_above_threshold)));
    endproperty
    a_cond: assert property (p_cond) else $error("threshold condition wrong");
    property p_filt;
        $past(i_rst_n) |-> o_temp_filtered == $past(s_reg[7]);
    endproperty
    a_filt: assert property (p_filt) else $error("temp filter wrong");
    property p_single;
        $past(i_rst_n) |-> o_temp_single_conversion
            == (!$past(s_reg[7]) && $past(i_axis_channel_enable) != 4'h0);
    endproperty
    a_single: assert property (p_single) else $error("single conversion wrong");
    property p_range;
        $past(i_rst_n) |-> {o_xy_wide_range, o_z_wide_range} == $past(s_reg[1:0]);
    endproperty
    a_range: assert property (p_range) else $error("range bits wrong");
    property p_angle;
        $past(i_rst_n) |-> o_angle_enable == ($past(s_reg[3:2]) != 2'h0);
    endproperty
    a_angle: assert property (p_angle) else $error("angle enable wrong");
endmodule : hall_cfg_checker
bind hall_sensor_config_threshold_regs hall_cfg_checker hall_cfg_checker_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .o_rd_valid(o_rd_valid),
    .i_axis_channel_enable(i_axis_channel_enable),
    .i_threshold_function_select(i_threshold_function_select),
    .i_irq_event(i_irq_event),
    .i_field_above_threshold(i_field_above_threshold),
    .i_field_below_threshold(i_field_below_threshold),
    .o_temp_single_conversion(o_temp_single_conversion),
    .o_temp_filtered(o_temp_filtered),
    .o_interrupt_pin_n(o_interrupt_pin_n),
    .o_threshold_condition(o_threshold_condition),
    .o_angle_enable(o_angle_enable),
    .o_xy_wide_range(o_xy_wide_range),
    .o_z_wide_range(o_z_wide_range)
);
`default_nettype wire

//--- dv/host_port_model.sv
`default_nettype none
module host_port_model (
    input wire logic i_clk,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_wr_en = 1'h0;
        o_rd_en = 1'h0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // Idle bus shows inverted last values so stale data cannot pass
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v);
        @(negedge i_clk);
        o_wr_en = wr;
        o_rd_en = !wr;
        o_addr = a;
        o_wr_data = d;
        @(negedge i_clk);
        q = i_rd_data;
        v = i_rd_valid;
        o_wr_en = 1'h0;
        o_rd_en = 1'h0;
        o_addr = ~a;
        o_wr_data = ~d;
    endtask : xfer
endmodule : host_port_model
`default_nettype wire

//--- dv/test_hall_sensor_config_threshold_regs.sv
`default_nettype none
module test_hall_sensor_config_threshold_regs import hall_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, wr_en, rd_en, rd_valid, irq, above, below;
    logic tsc, tf, pin, cond, aen, xyw, zw;
    logic [7:0] addr, wr_data, rd_data;
    logic [3:0] ace;
    logic [1:0] sel;
    axis_t fa, sa, ga, e1, e2;
    logic signed [7:0] lv [8];
    int n_mismatch = 0;
    int tests_run = 0;
    logic [7:0] p [4] = '{8'hA5, 8'h80, 8'h7F, 8'hFF};
    logic [7:0] t [3] = '{8'h81, 8'h7F, 8'h80};
    hall_sensor_config_threshold_regs hall_sensor_config_threshold_regs_i (.i_clk(clk),
        .i_rst_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .i_axis_channel_enable(ace), .i_threshold_function_select(sel), .i_irq_event(irq),
        .i_field_above_threshold(above), .i_field_below_threshold(below),
        .o_temp_single_conversion(tsc), .o_temp_filtered(tf), .o_interrupt_pin_n(pin),
        .o_threshold_condition(cond), .o_angle_enable(aen), .o_angle_first_axis(fa),
        .o_angle_second_axis(sa), .o_gain_axis(ga), .o_xy_wide_range(xyw),
        .o_z_wide_range(zw), .o_angle_reference_level(lv[0]), .o_angle_band_width(lv[1]),
        .o_angle_offset_level(lv[2]), .o_x_low_level(lv[3]), .o_y_low_level(lv[4]),
        .o_z_low_level(lv[5]), .o_magnitude_low_level(lv[6]),
        .o_magnitude_high_level(lv[7]));
    host_port_model host_port_model_i (.i_clk(clk), .i_rd_valid(rd_valid),
        .i_rd_data(rd_data), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wr_data(wr_data));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        host_port_model_i.xfer(1'h1, a, d, q, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic v;
        host_port_model_i.xfer(1'h0, a, 8'h00, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, exp);
    endtask : rd
    task automatic stop_test();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #500000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        logic [7:0] k;
        rst_n = 1'h0;
        ace = 4'h0;
        sel = 2'h0;
        irq = 1'h0;
        above = 1'h0;
        below = 1'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        for (k = 8'h03; k < 8'h08; k++) rd(k, 8'h00);
        wr(8'h07, 8'hFF);
        for (k = 8'h00; k < 8'h04; k++) wr(8'h03 + k, p[k]);
        for (k = 8'h00; k < 8'h05; k++) rd(8'h03 + k, k < 8'h04 ? p[k] : 8'h00);
        for (k = 8'h00; k < 8'h20; k++) begin
            wr(8'h03, k);
            @(negedge clk);
            e1 = k[3:2] == 2'h0 ? AXIS_NONE : k[3:2] == 2'h2 ? AXIS_Y : AXIS_X;
            e2 = k[3:2] == 2'h0 ? AXIS_NONE : k[3:2] == 2'h1 ? AXIS_Y : AXIS_Z;
            chk({6'h00, fa}, {6'h00, e1});
            chk({6'h00, sa}, {6'h00, e2});
            chk({6'h00, ga}, {6'h00, k[4] ? e2 : e1});
            chk({7'h00, aen}, {7'h00, k[3:2] != 2'h0});
            chk({6'h00, xyw, zw}, {6'h00, k[1:0]});
        end
        for (k = 8'h00; k < 8'h08; k++) begin
            wr(8'h03, {k[2:0], 5'h00});
            for (int j = 0; j < 4; j++) begin
                irq = j[0];
                above = j[0];
                below = !j[0];
                sel = j[1] ? 2'h2 : 2'h0;
                ace = {3'h0, j[0]};
                @(negedge clk);
                chk({7'h00, pin}, {7'h00, k[1] ? j[0] : !j[0]});
                chk({7'h00, cond}, {7'h00, j[1] && (k[0] ^ j[0])});
                chk({6'h00, tf, tsc}, {6'h00, k[2], !k[2] && j[0]});
            end
        end
        for (k = 8'h00; k < 8'h03; k++) wr(8'h04 + k, t[k]);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            repeat (2) @(negedge clk);
            chk(lv[0], s == 1 ? t[0] : 8'h00);
            chk(lv[1], s == 1 ? t[1] : 8'h00);
            chk(lv[2], s[0] ? t[2] : 8'h00);
            chk(lv[3], s == 2 ? t[0] : 8'h00);
            chk(lv[4], s == 2 ? t[1] : 8'h00);
            chk(lv[5], s == 2 ? t[2] : 8'h00);
            chk(lv[6], s == 3 ? t[0] : 8'h00);
            chk(lv[7], s == 3 ? t[1] : 8'h00);
        end
        // Mid-run reset must clear bytes that were written, not only power-up state
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        chk({7'h00, pin}, 8'h01);
        for (k = 8'h03; k < 8'h07; k++) rd(k, 8'h00);
        chk(lv[6], 8'h00);
        stop_test();
    end
endmodule : test_hall_sensor_config_threshold_regs
`default_nettype wire
